// >>> hw/dbtf_top.sv
// Decimating band translation filter with its output FIFO
// Behaviour
// RULE1 - Each channel takes 12-bit converter samples at nominal 102.4 kHz.
// RULE2 - With the 10 kHz span the converter rate is lowered to 81.92 kHz.
// RULE3 - All spans but the 25 kHz one are filtered digitally.
// RULE4 - The filter is a chain of eight stages, each bypass, /2 or /5.
// RULE5 - The 1 Hz span uses five /5 and three /2 stages, total 25,000.
// RULE6 - Only samples at four times the span width are kept.
// RULE7 - Kept samples fill a record of 1024 real points, 512 when dual.
// RULE8 - In baseband mode only the first filter of a channel produces data.
// RULE9 - In start and center modes both filters of a channel run.
// RULE10 - The first filter mixes each sample with the oscillator cosine.
// RULE11 - First filter output is the real part, second the imaginary part.
// RULE12 - A complex record holds 512 points, 256 when dual.
// RULE13 - Both channels use identical filter logic on their own data.
// RULE14 - The second filter mixes each sample with the oscillator sine.
// RULE15 - Each kept sample gives one single-cycle write into the buffer.
`timescale 1ns/10ps
`include "dbtf_defines.svh"
`default_nettype none

module dbtf_fifo
    import dbtf_pkg::*;
#(
    parameter int W = 33,
    parameter int D = 16
)(
    input  wire logic         mclk_in,
    input  wire logic         rst_n_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                ov;
        logic [W-1:0]        od;
    } dbtf_fifo_s;
    dbtf_fifo_s s_ff;
    dbtf_fifo_s nxt_s;
    logic       take;
    logic       load;

    // Honest full: ready only while a slot is free
    assign in_ready_out  = (s_ff.cnt < (AW+1)'(D));
    assign out_valid_out = s_ff.ov;
    assign out_data_out  = s_ff.od;

    // Write side, registered read side
    always_comb
    begin
        nxt_s = s_ff;
        take  = in_valid_in && in_ready_out;
        load  = (!s_ff.ov || out_ready_in) && (s_ff.cnt != '0);
        if (take)
        begin
            nxt_s.mem[s_ff.wp] = in_data_in;
            nxt_s.wp = s_ff.wp + 1'b1;
        end
        if (load)
        begin
            nxt_s.od = s_ff.mem[s_ff.rp];
            nxt_s.rp = s_ff.rp + 1'b1;
            nxt_s.ov = 1'b1;
        end
        else if (out_ready_in)
        begin
            nxt_s.ov = 1'b0;
        end
        nxt_s.cnt = s_ff.cnt + (AW+1)'(take) - (AW+1)'(load);
    end

    // State register
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end
endmodule : dbtf_fifo

module dbtf_top
    import dbtf_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    input  wire logic [11:0] adc_a_in,
    input  wire logic [11:0] adc_b_in,
    input  wire logic        adc_valid_in,
    output logic             rate_sel_out,
    output logic             buf_valid_out,
    input  wire logic        buf_ready_in,
    output logic [32:0]      buf_data_out
);
    dbtf_top_s   s_ff;
    dbtf_top_s   nxt_s;
    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic        fifo_ready;
    logic        accept;
    dbtf_mode_e  mode;
    logic        dual;
    logic [10:0] rec_len;

    // Cosine table, 16 points per turn
    function automatic logic signed [7:0] lo_cos(input logic [3:0] idx);
        case (idx)
            4'h0: lo_cos = 8'sh7f;
            4'h1, 4'hf: lo_cos = 8'sh75;
            4'h2, 4'he: lo_cos = 8'sh5a;
            4'h3, 4'hd: lo_cos = 8'sh31;
            4'h4, 4'hc: lo_cos = 8'sh00;
            4'h5, 4'hb: lo_cos = -8'sh31;
            4'h6, 4'ha: lo_cos = -8'sh5a;
            4'h7, 4'h9: lo_cos = -8'sh75;
            default: lo_cos = -8'sh7f;
        endcase
    endfunction : lo_cos

    // Sample times oscillator value, rescaled by 1/128
    function automatic logic signed [15:0] mix(input logic signed [15:0] x,
                                               input logic signed [7:0]  c);
        logic signed [23:0] p;
        p   = x * c;
        mix = p[22:7];
    endfunction : mix

    // Boxcar output gain: /2 for two taps, about /5 for five
    function automatic logic signed [19:0] dscale(input logic signed [19:0] v,
                                                  input logic five);
        logic signed [27:0] p;
        p      = 28'(v) * 28'sd13;
        dscale = five ? 20'(p >>> 6) : (v >>> 1);
    endfunction : dscale

    // Reset released through two flops
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    assign mode    = dbtf_mode_e'(s_ff.ctrl[`DBTF_CTRL_MODE_HI:`DBTF_CTRL_MODE_LO]);
    assign dual    = s_ff.ctrl[`DBTF_CTRL_DUAL];
    // Record length per mode and channel count
    assign rec_len = (mode == DBTF_BASEBAND) ?
                     (dual ? `DBTF_REC_REAL_TWO : `DBTF_REC_REAL_ONE) :  // [RULE7]
                     (dual ? `DBTF_REC_CPLX_TWO : `DBTF_REC_CPLX_ONE);   // [RULE12]
    // A full buffer stalls sample intake
    assign accept  = adc_valid_in && s_ff.ctrl[`DBTF_CTRL_RUN] &&
                     (s_ff.rec == DBTF_FILL) && fifo_ready;

    assign rdata_out    = s_ff.rdata;
    assign rate_sel_out = s_ff.rate_sel;

    // Register access, filter chain and record control
    always_comb
    begin
        logic signed [15:0]       x;
        logic signed [19:0]       v;
        logic                     vld;
        logic [1:0]               sm;
        logic [2:0]               last;
        logic [3:0]               fv;
        logic [3:0][15:0]         fo;
        logic signed [7:0]        lc;
        logic signed [7:0]        ls;
        x     = '0;
        v     = '0;
        vld   = 1'b0;
        sm    = 2'h0;
        last  = 3'h0;
        fv    = '0;
        fo    = '0;
        nxt_s = s_ff;
        lc    = lo_cos(s_ff.phase[15:12]);
        ls    = lo_cos(s_ff.phase[15:12] - 4'h4);  // [RULE14]
        nxt_s.push  = 1'b0;
        nxt_s.rdata = '0;
        nxt_s.rate_sel = s_ff.ctrl[`DBTF_CTRL_SPAN10K];  // [RULE2]
        // Filters 0/1 on channel A, 2/3 on channel B, same logic
        for (int f = 0; f < `DBTF_NUM_FILT; f++)  // [RULE13]
        begin
            x   = 16'(signed'(f < 2 ? adc_a_in : adc_b_in));  // [RULE1]
            vld = accept && (f < 2 || dual);
            if (mode != DBTF_BASEBAND)  // [RULE9]
                x = (f % 2 == 0) ? mix(x, lc) : mix(x, ls);  // [RULE10] [RULE14]
            else if (f % 2 == 1)
                vld = 1'b0;  // [RULE8]
            v = 20'(x);
            for (int g = 0; g < `DBTF_NUM_STAGES; g++)  // [RULE4]
            begin
                sm   = s_ff.stages[2*g +: 2];
                last = (sm == DBTF_DIV5) ? 3'h4 : 3'h1;
                // Code 3 is unused and bypasses like code 0
                if ((sm == DBTF_DIV2 || sm == DBTF_DIV5) && vld)  // [RULE3]
                begin
                    if (s_ff.cnt[f][g] == last)
                    begin
                        v = dscale(s_ff.acc[f][g] + v,
                                   sm == DBTF_DIV5);  // [RULE5]
                        nxt_s.acc[f][g] = '0;
                        nxt_s.cnt[f][g] = '0;
                    end
                    else
                    begin
                        nxt_s.acc[f][g] = s_ff.acc[f][g] + v;
                        nxt_s.cnt[f][g] = s_ff.cnt[f][g] + 3'h1;
                        vld = 1'b0;  // [RULE6]
                    end
                end
            end
            fv[f] = vld;
            fo[f] = v[15:0];
        end
        if (accept)
            nxt_s.phase = s_ff.phase + s_ff.lo_inc;  // [RULE10]
        // Push channel A now, channel B one cycle later
        if (s_ff.pend_b)
        begin
            nxt_s.push      = 1'b1;
            nxt_s.push_word = s_ff.word_b;
            nxt_s.pend_b    = 1'b0;
        end
        if (fv[0])
        begin
            nxt_s.push      = 1'b1;  // [RULE15]
            nxt_s.push_word = '{1'b0, fo[0], fo[1] & {16{fv[1]}}};  // [RULE11]
            nxt_s.pend_b    = fv[2];
            nxt_s.word_b    = '{1'b1, fo[2], fo[3] & {16{fv[3]}}};
            nxt_s.points    = s_ff.points + 11'h1;
            if (s_ff.points + 11'h1 == rec_len)
                nxt_s.rec = DBTF_DONE;  // [RULE7] [RULE12]
        end
        // A word lost to a full buffer is flagged, set beats clear
        if (wr_in && addr_in == `DBTF_ADDR_STATUS &&
            wdata_in[`DBTF_STAT_OVERRUN])
            nxt_s.overrun = 1'b0;
        if ((adc_valid_in && s_ff.rec == DBTF_FILL && !fifo_ready) ||
            (s_ff.push && !fifo_ready))
            nxt_s.overrun = 1'b1;
        // Register writes
        if (wr_in)
        begin
            case (addr_in)
                `DBTF_ADDR_CTRL:
                begin
                    nxt_s.ctrl   = wdata_in[4:0];
                    nxt_s.rec    = wdata_in[`DBTF_CTRL_RUN] ? DBTF_FILL
                                                           : DBTF_IDLE;
                    nxt_s.points = '0;
                    nxt_s.phase  = '0;
                    nxt_s.acc    = '0;
                    nxt_s.cnt    = '0;
                    nxt_s.pend_b = 1'b0;
                end
                `DBTF_ADDR_STAGES: nxt_s.stages = wdata_in[15:0];
                `DBTF_ADDR_LOINC:  nxt_s.lo_inc = wdata_in[15:0];
                default: ;
            endcase
        end
        // Register reads, data valid in the next cycle only
        if (rd_in)
        begin
            case (addr_in)
                `DBTF_ADDR_CTRL:   nxt_s.rdata = {27'h0, s_ff.ctrl};
                `DBTF_ADDR_STAGES: nxt_s.rdata = {16'h0, s_ff.stages};
                `DBTF_ADDR_LOINC:  nxt_s.rdata = {16'h0, s_ff.lo_inc};
                `DBTF_ADDR_STATUS:
                    nxt_s.rdata = {5'h0, s_ff.points, 14'h0, s_ff.overrun,
                                   s_ff.rec == DBTF_DONE};
                default:           nxt_s.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_ff        <= '0;
            s_ff.ctrl   <= `DBTF_CTRL_RST;
            s_ff.stages <= `DBTF_STAGES_RST;
            s_ff.lo_inc <= `DBTF_LOINC_RST;
        end
        else
            s_ff <= nxt_s;
    end

    // Time buffer queue
    dbtf_fifo #(.W(33), .D(`DBTF_FIFO_DEPTH)) u_fifo (
        .mclk_in       (mclk_in),
        .rst_n_in      (rst_n),
        .in_valid_in   (s_ff.push),
        .in_ready_out  (fifo_ready),
        .in_data_in    (s_ff.push_word),
        .out_valid_out (buf_valid_out),
        .out_ready_in  (buf_ready_in),
        .out_data_out  (buf_data_out)
    );

    // Checks
    AST_RATE_SEL: assert property (@(posedge mclk_in) disable iff (!rst_n)
        wr_in && addr_in == `DBTF_ADDR_CTRL |-> ##2
        rate_sel_out == $past(wdata_in[`DBTF_CTRL_SPAN10K], 2)) // [RULE2]
        else $error("rate select does not follow span");
    AST_BYPASS: assert property (@(posedge mclk_in) disable iff (!rst_n)
        accept && s_ff.stages == 16'h0 && !wr_in |=> s_ff.push) // [RULE3]
        else $error("bypassed chain did not pass sample");
    AST_DIV2: assert property (@(posedge mclk_in) disable iff (!rst_n)
        accept && s_ff.stages == 16'h0001 && s_ff.cnt[0][0] == 3'h0
        && !wr_in |=> !s_ff.push) // [RULE6]
        else $error("divide stage passed first sample");
    AST_BASE_IMAG: assert property (@(posedge mclk_in) disable iff (!rst_n)
        s_ff.push && mode == DBTF_BASEBAND |-> s_ff.push_word.im == 16'h0) // [RULE8]
        else $error("imaginary data in baseband mode");
    AST_REC_LEN: assert property (@(posedge mclk_in) disable iff (!rst_n)
        s_ff.points <= rec_len) // [RULE7]
        else $error("record overran its length");
    AST_DONE_STOP: assert property (@(posedge mclk_in) disable iff (!rst_n)
        s_ff.rec == DBTF_DONE && !s_ff.pend_b && !wr_in |=> !s_ff.push) // [RULE12]
        else $error("write after record complete");
    AST_PUSH_PULSE: assert property (@(posedge mclk_in) disable iff (!rst_n)
        s_ff.push ##1 s_ff.push |->
        s_ff.push_word.chan != $past(s_ff.push_word.chan)) // [RULE15]
        else $error("same channel written twice in a row");
    AST_SINGLE: assert property (@(posedge mclk_in) disable iff (!rst_n)
        !dual |-> !(s_ff.push && s_ff.push_word.chan)) // [RULE13]
        else $error("channel B written in single mode");
    AST_LO_STEP: assert property (@(posedge mclk_in) disable iff (!rst_n)
        accept && !wr_in |=>
        s_ff.phase == 16'($past(s_ff.phase) + $past(s_ff.lo_inc))) // [RULE10]
        else $error("oscillator phase did not advance");
    COV_DONE: cover property (@(posedge mclk_in) disable iff (!rst_n)
        s_ff.rec == DBTF_FILL ##1 s_ff.rec == DBTF_DONE);
    COV_DUAL: cover property (@(posedge mclk_in) disable iff (!rst_n)
        s_ff.push && s_ff.push_word.chan);
    COV_FULL: cover property (@(posedge mclk_in) disable iff (!rst_n)
        !fifo_ready);
endmodule : dbtf_top
`default_nettype wire

// >>> hw/dbtf_defines.svh
// Register map, field positions, reset values and record sizes
`ifndef DBTF_DEFINES_SVH
`define DBTF_DEFINES_SVH
`define DBTF_ADDR_CTRL      8'h00
`define DBTF_ADDR_STAGES    8'h04
`define DBTF_ADDR_LOINC     8'h08
`define DBTF_ADDR_STATUS    8'h0c
`define DBTF_CTRL_RUN       0
`define DBTF_CTRL_MODE_LO   1
`define DBTF_CTRL_MODE_HI   2
`define DBTF_CTRL_DUAL      3
`define DBTF_CTRL_SPAN10K   4
`define DBTF_STAT_DONE      0
`define DBTF_STAT_OVERRUN   1
`define DBTF_STAT_PTS_LO    16
`define DBTF_CTRL_RST       5'h00
`define DBTF_STAGES_RST     16'h0000
`define DBTF_LOINC_RST      16'h0000
`define DBTF_NUM_STAGES     8
`define DBTF_NUM_FILT       4
`define DBTF_REC_REAL_ONE   11'd1024
`define DBTF_REC_REAL_TWO   11'd512
`define DBTF_REC_CPLX_ONE   11'd512
`define DBTF_REC_CPLX_TWO   11'd256
`define DBTF_FIFO_DEPTH     16
`endif

// >>> hw/dbtf_pkg.sv
// Types shared by the decimating band translation filter
package dbtf_pkg;
    // Span mode selected by software
    typedef enum logic [1:0] {
        DBTF_BASEBAND = 2'h0,
        DBTF_START    = 2'h1,
        DBTF_CENTER   = 2'h2
    } dbtf_mode_e;
    // Record fill state, Gray coded along idle, fill, done
    typedef enum logic [1:0] {
        DBTF_IDLE = 2'h0,
        DBTF_FILL = 2'h1,
        DBTF_DONE = 2'h3
    } dbtf_rec_e;
    // Per-stage setting
    typedef enum logic [1:0] {
        DBTF_BYP  = 2'h0,
        DBTF_DIV2 = 2'h1,
        DBTF_DIV5 = 2'h2
    } dbtf_stage_e;
    // One time buffer word: channel, real part, imaginary part
    typedef struct packed {
        logic               chan;
        logic signed [15:0] re;
        logic signed [15:0] im;
    } dbtf_word_s;
    // Whole state of the filter top
    typedef struct packed {
        logic [4:0]              ctrl;
        logic [15:0]             stages;
        logic [15:0]             lo_inc;
        logic [15:0]             phase;
        logic [3:0][7:0][19:0]   acc;
        logic [3:0][7:0][2:0]    cnt;
        dbtf_rec_e               rec;
        logic [10:0]             points;
        logic                    overrun;
        logic                    pend_b;
        dbtf_word_s              word_b;
        logic                    push;
        dbtf_word_s              push_word;
        logic [31:0]             rdata;
        logic                    rate_sel;
    } dbtf_top_s;
endpackage : dbtf_pkg

// >>> dv/dbtf_far_model.sv
// Converter and time buffer stand-in for the filter bench
`timescale 1ns/10ps
`default_nettype none

module dbtf_far_model
    import dbtf_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        go_in,
    input  wire logic [15:0] n_in,
    input  wire logic        rate_sel_in,
    input  wire logic        hold_in,
    input  wire logic        stall_in,
    output logic [11:0]      adc_a_out,
    output logic [11:0]      adc_b_out,
    output logic             adc_valid_out,
    output logic             busy_out,
    output logic             buf_ready_out
);
    logic [15:0] left_ff = 16'h0000;
    logic [11:0] k_ff    = 12'h000;
    logic [1:0]  gap_ff  = 2'h0;
    logic [1:0]  cyc_ff  = 2'h0;

    initial
    begin
        adc_a_out     = 12'h000;
        adc_b_out     = 12'h000;
        adc_valid_out = 1'b0;
    end

    // Conversions every 2 cycles, every 3 at the lowered rate
    always @(posedge mclk_in)
    begin
        cyc_ff        <= cyc_ff + 2'h1;
        adc_valid_out <= 1'b0;
        adc_a_out     <= ~adc_a_out;  // Stale data never lingers
        adc_b_out     <= ~adc_b_out;
        if (go_in)
        begin
            left_ff <= n_in;
            k_ff    <= 12'h000;
            gap_ff  <= 2'h0;
        end
        else if (gap_ff != 2'h0)
            gap_ff <= gap_ff - 2'h1;
        else if (left_ff != 16'h0000)
        begin
            adc_valid_out <= 1'b1;
            adc_a_out     <= 12'h100 + k_ff;
            adc_b_out     <= 12'h100 + k_ff;
            k_ff          <= k_ff + 12'h001;
            left_ff       <= left_ff - 16'h0001;
            gap_ff        <= rate_sel_in ? 2'h2 : 2'h1;
        end
    end

    // Buffer side may be held off or stalled one cycle in four
    assign busy_out      = (left_ff != 16'h0000);
    assign buf_ready_out = !hold_in && !(stall_in && cyc_ff == 2'h0);
endmodule : dbtf_far_model

`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the decimating band translation filter
`timescale 1ns/10ps
`include "dbtf_defines.svh"
`default_nettype none

module tb_top
    import dbtf_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
        logic        r;
    } dbtf_reg_s;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] st;
        logic [15:0] n;
        logic [15:0] nw;
        logic [31:0] stat;
    } dbtf_row_s;
    localparam dbtf_reg_s REGS [0:4] = '{
        '{8'h00, 32'h10, 32'h10, 1'b1},
        '{8'h04, 32'hffff56aa, 32'h56aa, 1'b1},
        '{8'h08, 32'h1234abcd, 32'habcd, 1'b1},
        '{8'h10, 32'hffffffff, 32'h0, 1'b1},
        '{8'h00, 32'h0, 32'h0, 1'b0}};
    localparam dbtf_row_s ROWS [0:9] = '{
        '{32'h1, 16'h0000, 16'd8, 16'd8, 32'h00080000},
        '{32'h1, 16'h0003, 16'd8, 16'd8, 32'h00080000},
        '{32'h1, 16'h0001, 16'd10, 16'd5, 32'h00050000},
        '{32'h1, 16'h0002, 16'd10, 16'd2, 32'h00020000},
        '{32'h1, 16'h0005, 16'd20, 16'd5, 32'h00050000},
        '{32'h1, 16'h56aa, 16'd25000, 16'd1, 32'h00010000},
        '{32'h1, 16'h0000, 16'd1030, 16'd1024, 32'h04000001},
        '{32'h9, 16'h0000, 16'd520, 16'd1024, 32'h02000001},
        '{32'h3, 16'h0000, 16'd520, 16'd512, 32'h02000001},
        '{32'hd, 16'h0000, 16'd260, 16'd512, 32'h01000001}};

    logic        mclk = 1'b0;
    logic        rst_n, wr, rd, go, hold, stall;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic [15:0] n;
    logic [11:0] adc_a, adc_b, s;
    logic        adc_valid, rate_sel, buf_valid, buf_ready, busy;
    logic [32:0] buf_data;
    dbtf_word_s  words[$];
    dbtf_word_s  w;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          i, j, k, z_re, z_im;

    dbtf_top i_dbtf_top (.mclk_in(mclk), .rst_n_in(rst_n), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .adc_a_in(adc_a), .adc_b_in(adc_b), .adc_valid_in(adc_valid),
        .rate_sel_out(rate_sel), .buf_valid_out(buf_valid),
        .buf_ready_in(buf_ready), .buf_data_out(buf_data));
    dbtf_far_model i_dbtf_far_model (.mclk_in(mclk), .go_in(go), .n_in(n),
        .rate_sel_in(rate_sel), .hold_in(hold), .stall_in(stall),
        .adc_a_out(adc_a), .adc_b_out(adc_b), .adc_valid_out(adc_valid),
        .busy_out(busy), .buf_ready_out(buf_ready));

    // 125 MHz clock
    always #4 mclk = ~mclk;

    // Collect every word the time buffer takes
    always @(posedge mclk)
        if (rst_n && buf_valid === 1'b1 && buf_ready)
            words.push_back(buf_data);

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Checked %0d, mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : bus_rd

    // Program stages and mode, feed n samples, let the buffer drain
    task automatic run_rec(input logic [31:0] c, input logic [15:0] st,
                           input logic [15:0] cnt);
        int t;
        bus_wr(`DBTF_ADDR_STAGES, {16'h0000, st});
        bus_wr(`DBTF_ADDR_CTRL, c);
        words.delete();
        @(posedge mclk);
        go <= 1'b1;
        n  <= cnt;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        for (t = 0; t < 60000 && busy; t++)
            @(posedge mclk);
        repeat (40) @(posedge mclk);
    endtask : run_rec

    // Cut a hang short
    initial
    begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        test_done();
    end

    // Reset, register rows, stream rows, then the awkward cases
    initial
    begin
        rst_n = 1'b0;
        {wr, rd, go, hold, stall} = 5'h00;
        addr  = 8'h00;
        wdata = 32'h0;
        n     = 16'h0;
        repeat (10) @(posedge mclk);
        check({rdata, buf_valid, rate_sel}, 34'h0);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        for (i = 0; i < 4; i++)
        begin
            bus_rd(8'(i * 4), d);
            check(d, 32'h0);
        end
        foreach (REGS[r])
        begin
            bus_wr(REGS[r].a, REGS[r].d);
            bus_rd(REGS[r].a, d);
            check(d, REGS[r].e);
            check(rate_sel, REGS[r].r);
        end
        foreach (ROWS[r])
        begin
            run_rec(ROWS[r].ctrl, ROWS[r].st, ROWS[r].n);
            check(words.size(), ROWS[r].nw);
            bus_rd(`DBTF_ADDR_STATUS, d);
            check(d, ROWS[r].stat);
            if (ROWS[r].st == 16'h0000 && ROWS[r].ctrl[2:1] == 2'h0)
                foreach (words[x])
                begin
                    k = ROWS[r].ctrl[3] ? x / 2 : x;
                    s = 12'h100 + 12'(k);
                    w = words[x];
                    check(w.chan, ROWS[r].ctrl[3] ? x % 2 : 0);
                    check({w.re, w.im}, {{4{s[11]}}, s, 16'h0});
                end
        end
        // Oscillator at rest: cosine only, sine zero, both channels alike
        bus_wr(`DBTF_ADDR_LOINC, 32'h0);
        run_rec(32'hb, 16'h0000, 16'd4);
        check(words.size(), 8);
        foreach (words[x])
        begin
            check(words[x].im, 16'h0);
            check($signed(words[x].re) > 0, 1'b1);
            check(words[x].re, words[x & 6].re);
        end
        // Quarter-turn steps: each word is purely real or purely imaginary
        bus_wr(`DBTF_ADDR_LOINC, 32'h4000);
        run_rec(32'h3, 16'h0000, 16'd4);
        {z_re, z_im} = 0;
        foreach (words[x])
        begin
            z_re += (words[x].re == 16'h0);
            z_im += (words[x].im == 16'h0);
        end
        check({z_re[7:0], z_im[7:0]}, 16'h0202);
        // Buffer held off: FIFO fills, refuses, overrun sticks
        hold <= 1'b1;
        run_rec(32'h1, 16'h0000, 16'd24);
        check({buf_valid, words.size() == 0}, 2'h3);
        bus_rd(`DBTF_ADDR_STATUS, d);
        check(d[1], 1'b1);
        bus_wr(`DBTF_ADDR_STATUS, 32'h2);
        bus_rd(`DBTF_ADDR_STATUS, d);
        check(d[1], 1'b0);
        hold  <= 1'b0;
        stall <= 1'b1;
        repeat (100) @(posedge mclk);
        check(words.size() >= 16 && words.size() < 24, 1'b1);
        for (j = 0; j < 16 && j < words.size(); j++)
            check(words[j].re, 16'h100 + 16'(j));
        stall <= 1'b0;
        // Reset in mid-run clears outputs and registers
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        check({rdata, buf_valid, rate_sel}, 34'h0);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        bus_rd(`DBTF_ADDR_LOINC, d);
        check(d, 32'h0);
        bus_rd(`DBTF_ADDR_STATUS, d);
        check(d, 32'h0);
        test_done();
    end
endmodule : tb_top

`default_nettype wire
